// ---- umaf_top.sv ----
// Multidrop serial port: address filter on received characters, framed transmitter
// with driver enable, and 16-bit baud generator with live readback.
// Assumes received characters arrive already deserialised as data plus ninth bit.
`timescale 1ns/1ps
`include "umaf_cfg.svh"
// Contract
// [RULE1] Address filtering and ninth-bit handling act only while ninth_bit_enable is 1.
// [RULE2] Mode 00 interrupts on every received byte, address or data.
// [RULE3] Mode 01 interrupts on address bytes only, never on data bytes.
// [RULE4] Mode 10 interrupts on matching address and its data; mismatch frames are ignored.
// [RULE5] frame_first_flag is 1 on first data byte after match, 0 later.
// [RULE6] Mode 11 is mode 10 without interrupts on matching address bytes.
// [RULE7] rx_marker_flag shows whether the current byte was address-marked.
// [RULE8] Transmitter sends tx_marker_bit as ninth bit when ninth-bit mode is on.
// [RULE9] driver_en_polarity 0 makes driver enable active high, 1 active low.
// [RULE10] With baud interrupt enabled, each generator reload pulses the receive interrupt.
// [RULE11] Baud generator divides the clock by the 16-bit divisor from two bytes.
// [RULE12] Receiver off: baud_gen_ctrl 1 interrupts at zero and reads live count.
// [RULE13] Receiver on: baud_gen_ctrl only selects live count or reload readback.
// [RULE14] High byte read never latches the low byte; bytes sample independently.
// [RULE15] rx_irq_ctrl 0 lets both data and receive errors request interrupts.
// [RULE16] Software toggles filter mode bit 0 in address-only mode per frame.
// [RULE17] Driver enable is active from start bit through stop bit of each character.
module umaf_top
  import umaf_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic ninth_bit_enable_in,
  input wire logic [1:0] filter_mode_sel_in,
  input wire logic [7:0] addr_compare_in,
  input wire logic rx_enable_in,
  input wire logic rx_irq_ctrl_in,
  input wire logic baud_gen_ctrl_in,
  input wire logic baud_irq_enable_in,
  input wire logic [7:0] baud_hi_in,
  input wire logic [7:0] baud_lo_in,
  input wire logic rx_valid_in,
  input wire logic [7:0] rx_data_in,
  input wire logic rx_ninth_in,
  input wire logic rx_error_in,
  input wire logic rx_read_in,
  output logic [7:0] rx_byte_out,
  output logic rx_marker_flag_out,
  output logic frame_first_flag_out,
  output logic rx_irq_out,
  output logic [7:0] baud_read_hi_out,
  output logic [7:0] baud_read_lo_out,
  input wire logic tx_valid_in,
  output logic tx_ready_out,
  input wire logic [7:0] tx_data_in,
  input wire logic tx_marker_bit_in,
  input wire logic driver_en_polarity_in,
  output logic tx_serial_out,
  output logic driver_en_out
);
  logic [15:0] divisor;
  logic [15:0] baud_cnt_q;
  logic baud_reload;
  logic baud_tick;
  logic match_q;
  logic accept;
  logic irq_byte;
  logic first_pend_q;
  logic [7:0] rx_byte_q;
  logic marker_q;
  logic first_q;
  logic irq_q;
  logic fifo_valid;
  logic fifo_ready;
  logic [8:0] fifo_data;
  umaf_tx_state_type tx_state_q;
  logic [9:0] shift_q;
  logic [3:0] bit_cnt_q;
  logic [3:0] bits_total;
  logic tx_q;
  logic de_q;

  assign divisor = {baud_hi_in, baud_lo_in}; // [RULE11]
  assign baud_reload = (baud_cnt_q <= 16'h0001);
  assign baud_tick = baud_reload;

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      baud_cnt_q <= `UMAF_BAUD_RST;
    end
    else if (baud_reload)
    begin
      baud_cnt_q <= divisor; // [RULE11]
    end
    else
    begin
      baud_cnt_q <= baud_cnt_q - 16'h0001;
    end
  end

  // Each byte is chosen on its own, so a live count is not latched across reads.
  assign baud_read_hi_out = baud_gen_ctrl_in ? baud_cnt_q[15:8] : divisor[15:8]; // [RULE12] [RULE13] [RULE14]
  assign baud_read_lo_out = baud_gen_ctrl_in ? baud_cnt_q[7:0] : divisor[7:0]; // [RULE12] [RULE13] [RULE14]

  // Filter decision for one received character.
  always_comb
  begin
    accept = 1'b1;
    irq_byte = 1'b1;
    if (ninth_bit_enable_in) // [RULE1]
    begin
      case (filter_mode_sel_in)
        `UMAF_MODE_ALL:
        begin
          irq_byte = 1'b1; // [RULE2]
        end
        `UMAF_MODE_ADDR:
        begin
          irq_byte = rx_ninth_in; // [RULE3]
        end
        `UMAF_MODE_MATCH:
        begin
          accept = rx_ninth_in ? (rx_data_in == addr_compare_in) : match_q; // [RULE4]
          irq_byte = accept; // [RULE4]
        end
        `UMAF_MODE_DATA:
        begin
          accept = rx_ninth_in ? (rx_data_in == addr_compare_in) : match_q; // [RULE6]
          irq_byte = accept && !rx_ninth_in; // [RULE6]
        end
        default:
        begin
          irq_byte = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      match_q <= 1'b0;
      first_pend_q <= 1'b0;
    end
    else if (rx_valid_in && ninth_bit_enable_in && rx_ninth_in)
    begin
      match_q <= (rx_data_in == addr_compare_in); // [RULE4]
      first_pend_q <= (rx_data_in == addr_compare_in); // [RULE5]
    end
    else if (rx_valid_in && ninth_bit_enable_in && accept)
    begin
      first_pend_q <= 1'b0; // [RULE5]
    end
  end

  // Received byte and its status become visible together.
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      rx_byte_q <= 8'h00;
      marker_q <= 1'b0;
      first_q <= 1'b0;
    end
    else if (rx_valid_in && accept)
    begin
      rx_byte_q <= rx_data_in;
      marker_q <= ninth_bit_enable_in && rx_ninth_in; // [RULE7]
      first_q <= ninth_bit_enable_in && filter_mode_sel_in[1] && !rx_ninth_in
        && first_pend_q; // [RULE5]
    end
    else if (rx_read_in)
    begin
      first_q <= 1'b0;
    end
  end

  assign rx_byte_out = rx_byte_q;
  assign rx_marker_flag_out = marker_q;
  assign frame_first_flag_out = first_q;

  // Interrupt request is registered, high one cycle after each cycle that a condition raises it.
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      irq_q <= 1'b0;
    end
    else
    begin
      irq_q <= (rx_valid_in && irq_byte && !rx_irq_ctrl_in) // [RULE15]
        || (rx_error_in && !rx_irq_ctrl_in) // [RULE15]
        || (baud_reload && baud_irq_enable_in) // [RULE10]
        || (baud_reload && !rx_enable_in && baud_gen_ctrl_in); // [RULE12]
    end
  end

  assign rx_irq_out = irq_q;

  umaf_fifo #(
    .WIDTH(`UMAF_TX_W),
    .DEPTH(`UMAF_FIFO_DEPTH),
    .AW(`UMAF_FIFO_AW)
  ) u_tx_fifo (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .wr_valid_in(tx_valid_in),
    .wr_ready_out(tx_ready_out),
    .wr_data_in({tx_marker_bit_in, tx_data_in}),
    .rd_valid_out(fifo_valid),
    .rd_ready_in(fifo_ready),
    .rd_data_out(fifo_data)
  );

  assign fifo_ready = (tx_state_q == UMAF_TX_IDLE) && baud_tick;
  assign bits_total = ninth_bit_enable_in ? `UMAF_BITS_NINTH : `UMAF_BITS_PLAIN;

  // Transmit framing: start bit, eight data bits, optional marker, stop bit.
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      tx_state_q <= UMAF_TX_IDLE;
      shift_q <= 10'h000;
      bit_cnt_q <= 4'h0;
    end
    else if (baud_tick)
    begin
      case (tx_state_q)
        UMAF_TX_IDLE:
        begin
          if (fifo_valid)
          begin
            shift_q <= {1'b1, fifo_data}; // [RULE8]
            tx_state_q <= UMAF_TX_START;
          end
        end
        UMAF_TX_START:
        begin
          bit_cnt_q <= 4'h1;
          tx_state_q <= UMAF_TX_SHIFT;
        end
        UMAF_TX_SHIFT:
        begin
          shift_q <= {1'b1, shift_q[9:1]};
          if (bit_cnt_q == bits_total - 4'h1)
          begin
            tx_state_q <= UMAF_TX_STOP;
          end
          bit_cnt_q <= bit_cnt_q + 4'h1;
        end
        UMAF_TX_STOP:
        begin
          tx_state_q <= UMAF_TX_IDLE;
        end
        default:
        begin
          tx_state_q <= UMAF_TX_IDLE;
        end
      endcase
    end
  end

  // Line level and driver enable follow the state one baud tick later.
  // Keeping them apart from the sequencing lets the enable span the stop bit.
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      tx_q <= 1'b1;
      de_q <= 1'b0;
    end
    else if (baud_tick)
    begin
      case (tx_state_q)
        UMAF_TX_START:
        begin
          tx_q <= 1'b0;
          de_q <= 1'b1; // [RULE17]
        end
        UMAF_TX_SHIFT:
        begin
          tx_q <= shift_q[0]; // [RULE8]
        end
        UMAF_TX_STOP:
        begin
          tx_q <= 1'b1;
        end
        default:
        begin
          tx_q <= 1'b1;
          de_q <= 1'b0; // [RULE17]
        end
      endcase
    end
  end

  assign tx_serial_out = tx_q;
  assign driver_en_out = de_q ^ driver_en_polarity_in; // [RULE9]
endmodule // umaf_top

// ---- umaf_cfg.svh ----
// Constants for the multidrop address filter block: field codes, frame layout and reset values.
// Assumes inclusion by bare name from the top module only.
`ifndef UMAF_CFG_SVH
`define UMAF_CFG_SVH
`define UMAF_MODE_ALL 2'h0
`define UMAF_MODE_ADDR 2'h1
`define UMAF_MODE_MATCH 2'h2
`define UMAF_MODE_DATA 2'h3
`define UMAF_BAUD_RST 16'h0001
`define UMAF_FIFO_DEPTH 8
`define UMAF_FIFO_AW 3
`define UMAF_TX_W 9
`define UMAF_BITS_PLAIN 4'h9
`define UMAF_BITS_NINTH 4'hA
`endif

// ---- umaf_pkg.sv ----
// Types for the multidrop address filter block.
// Assumes umaf_cfg.svh is on the include path.
package umaf_pkg;
  typedef enum logic [3:0] {
    UMAF_TX_IDLE = 4'h1,
    UMAF_TX_START = 4'h2,
    UMAF_TX_SHIFT = 4'h4,
    UMAF_TX_STOP = 4'h8
  } umaf_tx_state_type;
endpackage

// ---- umaf_fifo.sv ----
// Small FIFO with valid and ready on both sides, read data taken unregistered from the head entry.
// Assumes one clock and an asynchronous active-low reset.
`timescale 1ns/1ps
module umaf_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 8,
  parameter int AW = 3
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic wr_valid_in,
  output logic wr_ready_out,
  input wire logic [WIDTH-1:0] wr_data_in,
  output logic rd_valid_out,
  input wire logic rd_ready_in,
  output logic [WIDTH-1:0] rd_data_out
);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [AW:0] cnt_q;
  logic do_wr;
  logic do_rd;

  // Read data is an unregistered read of the memory at the head entry.
  assign wr_ready_out = (cnt_q != DEPTH[AW:0]);
  assign rd_valid_out = (cnt_q != '0);
  assign do_wr = wr_valid_in && wr_ready_out;
  assign do_rd = rd_valid_out && rd_ready_in;
  assign rd_data_out = mem_q[rp_q];

  always_ff @(posedge clk_in)
  begin
    if (do_wr)
    begin
      mem_q[wp_q] <= wr_data_in;
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end
    else
    begin
      if (do_wr)
      begin
        wp_q <= wp_q + 1'b1;
      end
      if (do_rd)
      begin
        rp_q <= rp_q + 1'b1;
      end
      cnt_q <= cnt_q + {{AW{1'b0}}, do_wr} - {{AW{1'b0}}, do_rd};
    end
  end
endmodule // umaf_fifo

// ---- umaf_asserts.sv ----
// Checker on the top ports: receive interrupts, status flags, driver enable.
// Assumes one clock and the one-cycle receive answer of the top module.
`timescale 1ns/1ps
module umaf_asserts (
  input wire logic clk_in, rst_b_in, ninth_bit_enable_in, rx_irq_ctrl_in,
  input wire logic baud_gen_ctrl_in, baud_irq_enable_in, rx_valid_in, rx_ninth_in,
  input wire logic rx_error_in, rx_marker_flag_out, frame_first_flag_out, rx_irq_out,
  input wire logic tx_serial_out, driver_en_polarity_in, driver_en_out,
  input wire logic [1:0] filter_mode_sel_in,
  input wire logic [7:0] addr_compare_in, rx_data_in
);
  logic quiet, go, hit;
  assign quiet = !rx_error_in && !baud_irq_enable_in && !baud_gen_ctrl_in;
  assign go = rx_valid_in && ninth_bit_enable_in && quiet && !rx_irq_ctrl_in;
  assign hit = rx_data_in == addr_compare_in;
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_b_in);
  all_bytes_irq_a: assert property (go && filter_mode_sel_in == 2'h0 |=> rx_irq_out)
    else $error("byte missed its irq in mode 0");
  marker_copy_a: assert property (
    go && filter_mode_sel_in == 2'h0 |=> rx_marker_flag_out == $past(rx_ninth_in))
    else $error("marker flag wrong");
  addr_only_a: assert property (
    go && filter_mode_sel_in == 2'h1 |=> rx_irq_out == $past(rx_ninth_in))
    else $error("mode 1 irq wrong");
  mismatch_quiet_a: assert property (
    go && filter_mode_sel_in == 2'h2 && rx_ninth_in && !hit |=> !rx_irq_out)
    else $error("mismatched address raised irq");
  match_irq_a: assert property (go && filter_mode_sel_in == 2'h2 && rx_ninth_in && hit |=> rx_irq_out)
    else $error("matched address without irq");
  match_silent_a: assert property (go && filter_mode_sel_in == 2'h3 && rx_ninth_in |=> !rx_irq_out)
    else $error("address irq in mode 3");
  first_rise_a: assert property ($rose(frame_first_flag_out) |-> $past(rx_valid_in && !rx_ninth_in))
    else $error("first flag without data byte");
  first_clear_a: assert property (
    go && filter_mode_sel_in[1] && !rx_ninth_in && frame_first_flag_out
      |=> !(rx_irq_out && frame_first_flag_out))
    else $error("first flag stuck");
  irq_block_a: assert property (rx_valid_in && rx_irq_ctrl_in && quiet |=> !rx_irq_out)
    else $error("blocked irq seen");
  error_irq_a: assert property (rx_error_in && !rx_irq_ctrl_in |=> rx_irq_out)
    else $error("error without irq");
  de_active_a: assert property (!tx_serial_out |-> driver_en_out != driver_en_polarity_in)
    else $error("driver enable idle in frame");
  cover property (go && filter_mode_sel_in == 2'h2 && rx_ninth_in && hit);
  cover property (rx_irq_out && baud_irq_enable_in);
  cover property ($fell(tx_serial_out));
endmodule // umaf_asserts
bind umaf_top umaf_asserts umaf_asserts_i (.clk_in, .rst_b_in, .ninth_bit_enable_in,
  .rx_irq_ctrl_in, .baud_gen_ctrl_in, .baud_irq_enable_in, .rx_valid_in, .rx_ninth_in,
  .rx_error_in, .rx_marker_flag_out, .frame_first_flag_out, .rx_irq_out, .tx_serial_out,
  .driver_en_polarity_in, .driver_en_out, .filter_mode_sel_in, .addr_compare_in, .rx_data_in);

// ---- umaf_node.sv ----
// Model of another bus node: sends characters and decodes the serial line.
// Assumes the bit time equals the divisor given on div_in.
`timescale 1ns/1ps
module umaf_node (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic send_in,
  input wire logic [7:0] data_in,
  input wire logic ninth_in,
  input wire logic [15:0] div_in,
  input wire logic serial_in,
  output logic rx_valid_out,
  output logic [7:0] rx_data_out,
  output logic rx_ninth_out,
  output logic got_out,
  output logic [8:0] word_out
);
  logic busy_q;
  logic [3:0] n_q;
  logic [16:0] cnt_q;
  logic [9:0] sh_q;
  assign word_out = sh_q[8:0];
  // Idle data lines toggle so that a stale value is never seen as valid.
  always_ff @(posedge clk_in or negedge rst_b_in)
    if (!rst_b_in)
    begin
      rx_valid_out <= 1'b0;
      rx_data_out <= 8'h00;
      rx_ninth_out <= 1'b0;
    end
    else
    begin
      rx_valid_out <= send_in;
      rx_data_out <= send_in ? data_in : ~rx_data_out;
      rx_ninth_out <= send_in ? ninth_in : ~rx_ninth_out;
    end
  // Samples mid-bit: eight data bits, ninth bit, stop bit.
  always_ff @(posedge clk_in or negedge rst_b_in)
    if (!rst_b_in)
    begin
      busy_q <= 1'b0;
      n_q <= 4'h0;
      cnt_q <= 17'h00000;
      sh_q <= 10'h000;
      got_out <= 1'b0;
    end
    else
    begin
      got_out <= 1'b0;
      if (!busy_q)
      begin
        busy_q <= !serial_in;
        n_q <= 4'h0;
        cnt_q <= {1'b0, div_in} + {2'b00, div_in[15:1]};
      end
      else if (cnt_q > 17'h00001)
        cnt_q <= cnt_q - 17'h00001;
      else
      begin
        cnt_q <= {1'b0, div_in};
        sh_q <= {serial_in, sh_q[9:1]};
        n_q <= n_q + 4'h1;
        busy_q <= n_q != 4'h9;
        got_out <= n_q == 4'h9;
      end
    end
endmodule // umaf_node

// ---- umaf_top_tb_top.sv ----
// Self-checking bench for the multidrop filter, baud generator and transmitter.
// Assumes the node model on the serial side.
`timescale 1ns/1ps
module umaf_top_tb_top;
  logic clk_in = 1'b0, rst_b_in = 1'b0, ninth_bit_enable_in = 1'b1, rx_enable_in = 1'b1;
  logic rx_irq_ctrl_in = 1'b0, baud_gen_ctrl_in = 1'b0, baud_irq_enable_in = 1'b0;
  logic rx_error_in = 1'b0, rx_read_in = 1'b0, tx_valid_in = 1'b0, tx_marker_bit_in = 1'b0;
  logic driver_en_polarity_in = 1'b0, snd = 1'b0, snd_n = 1'b0;
  logic [1:0] filter_mode_sel_in = 2'h0;
  logic [7:0] addr_compare_in = 8'h5A, baud_hi_in = 8'h00, baud_lo_in = 8'h04;
  logic [7:0] tx_data_in = 8'h00, snd_d = 8'h00, rx_data_in, rx_byte_out;
  logic [7:0] baud_read_hi_out, baud_read_lo_out, a;
  logic rx_valid_in, rx_ninth_in, rx_marker_flag_out, frame_first_flag_out, rx_irq_out;
  logic tx_ready_out, tx_serial_out, driver_en_out, got;
  logic [8:0] word;
  logic [8:0] exp_q[$];
  int fail_count = 0, comparisons = 0, cyc = 0, n, k;
  umaf_top umaf_top_i (.clk_in, .rst_b_in, .ninth_bit_enable_in, .filter_mode_sel_in,
    .addr_compare_in, .rx_enable_in, .rx_irq_ctrl_in, .baud_gen_ctrl_in, .baud_irq_enable_in,
    .baud_hi_in, .baud_lo_in, .rx_valid_in, .rx_data_in, .rx_ninth_in, .rx_error_in,
    .rx_read_in, .rx_byte_out, .rx_marker_flag_out, .frame_first_flag_out, .rx_irq_out,
    .baud_read_hi_out, .baud_read_lo_out, .tx_valid_in, .tx_ready_out, .tx_data_in,
    .tx_marker_bit_in, .driver_en_polarity_in, .tx_serial_out, .driver_en_out);
  umaf_node umaf_node_i (.clk_in, .rst_b_in, .send_in(snd), .data_in(snd_d), .ninth_in(snd_n),
    .div_in({baud_hi_in, baud_lo_in}), .serial_in(tx_serial_out), .rx_valid_out(rx_valid_in),
    .rx_data_out(rx_data_in), .rx_ninth_out(rx_ninth_in), .got_out(got), .word_out(word));
  initial forever #20 clk_in = ~clk_in;
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    comparisons++;
    if (seen !== want)
    begin
      fail_count++;
      $display("CHECK FAILED at %0t: seen %h want %h", $time, seen, want);
    end
  endtask
  task automatic rx(input logic [7:0] d, input logic nb, input logic irq);
    @(posedge clk_in) {snd, snd_d, snd_n} <= {1'b1, d, nb};
    @(posedge clk_in) snd <= 1'b0;
    @(posedge clk_in) #1;
    check(rx_irq_out, irq);
  endtask
  task automatic mode(input logic [1:0] m);
    @(posedge clk_in) filter_mode_sel_in <= m;
  endtask
  task automatic t_filter;
    rx(8'h11, 1'b1, 1'b1);
    check(rx_marker_flag_out, 1'b1);
    rx(8'h22, 1'b0, 1'b1);
    check(rx_marker_flag_out, 1'b0);
    check(rx_byte_out, 8'h22);
    mode(2'h1);
    rx(addr_compare_in, 1'b1, 1'b1);
    rx(8'h23, 1'b0, 1'b0);
    mode(2'h0);
    rx(8'h24, 1'b0, 1'b1);
    mode(2'h2);
    rx(8'h11, 1'b1, 1'b0);
    rx(8'h25, 1'b0, 1'b0);
    check(rx_byte_out, 8'h24);
    rx(addr_compare_in, 1'b1, 1'b1);
    rx(8'h33, 1'b0, 1'b1);
    check(frame_first_flag_out, 1'b1);
    rx(8'h34, 1'b0, 1'b1);
    check(frame_first_flag_out, 1'b0);
    mode(2'h3);
    rx(addr_compare_in, 1'b1, 1'b0);
    rx(8'h35, 1'b0, 1'b1);
    check(frame_first_flag_out, 1'b1);
    @(posedge clk_in) rx_read_in <= 1'b1;
    @(posedge clk_in) rx_read_in <= 1'b0;
    #1 check(frame_first_flag_out, 1'b0);
    rx(8'h01, 1'b1, 1'b0);
    rx(8'h36, 1'b0, 1'b0);
    @(posedge clk_in) ninth_bit_enable_in <= 1'b0;
    rx(8'h01, 1'b1, 1'b1);
    check(rx_marker_flag_out, 1'b0);
    @(posedge clk_in) ninth_bit_enable_in <= 1'b1;
    mode(2'h0);
    @(posedge clk_in) rx_irq_ctrl_in <= 1'b1;
    rx(8'h37, 1'b0, 1'b0);
    @(posedge clk_in) {rx_irq_ctrl_in, rx_error_in} <= 2'b01;
    @(posedge clk_in) rx_error_in <= 1'b0;
    #1 check(rx_irq_out, 1'b1);
  endtask
  task automatic count_irq(input int want);
    repeat (12) @(posedge clk_in);
    n = 0;
    repeat (50) @(posedge clk_in) n += int'(rx_irq_out === 1'b1);
    check(n, want);
  endtask
  task automatic t_baud;
    @(posedge clk_in) {baud_lo_in, baud_irq_enable_in} <= {8'h05, 1'b1};
    count_irq(10);
    @(posedge clk_in) {baud_irq_enable_in, rx_enable_in, baud_gen_ctrl_in} <= 3'b001;
    count_irq(10);
    @(posedge clk_in) a = baud_read_lo_out;
    @(posedge clk_in) check(a != baud_read_lo_out && baud_read_hi_out == 8'h00, 1'b1);
    @(posedge clk_in) rx_enable_in <= 1'b1;
    count_irq(0);
    @(posedge clk_in) baud_gen_ctrl_in <= 1'b0;
    @(posedge clk_in) #1 check({baud_read_hi_out, baud_read_lo_out}, 16'h0005);
  endtask
  task automatic t_tx;
    @(posedge clk_in) {baud_lo_in, driver_en_polarity_in} <= {8'h04, 1'b1};
    repeat (30) @(posedge clk_in);
    check(driver_en_out, 1'b1);
    @(posedge clk_in) {tx_valid_in, tx_data_in, tx_marker_bit_in} <= {1'b1, 8'h80, 1'b1};
    for (k = 0; k < 14; k++)
    begin
      @(posedge clk_in);
      if (!tx_ready_out)
        break;
      exp_q.push_back({tx_marker_bit_in, tx_data_in});
      {tx_data_in, tx_marker_bit_in} <= {tx_data_in + 8'h01, ~tx_marker_bit_in};
    end
    tx_valid_in <= 1'b0;
    check(exp_q.size() >= 8 && k < 14, 1'b1);
    while (exp_q.size() > 0)
    begin
      for (k = 0; k < 300 && !got; k++)
        @(posedge clk_in);
      check(word, exp_q.pop_front());
      @(posedge clk_in);
    end
  endtask
  task automatic print_verdict;
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge clk_in)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fail_count++;
      print_verdict;
    end
  end
  initial
  begin
    repeat (8) @(posedge clk_in);
    rst_b_in <= 1'b1;
    t_filter;
    t_baud;
    t_tx;
    print_verdict;
  end
endmodule // umaf_top_tb_top
